// [rpu_cfg_pkg.sv]
package rpu_cfg_pkg;
	localparam int unsigned ADDR_W     = 32;
	localparam int unsigned DATA_W     = 32;
	localparam int unsigned CHECK_W    = 7;
	localparam int unsigned MEM_IDX_W  = 15;
	localparam int unsigned MEM_DEPTH  = 32768;
	localparam logic [31:0] LOCAL_FIRST_BASE   = 32'h0000_0000;
	localparam logic [31:0] LOCAL_SECOND_BASE  = 32'h0002_0000;
	localparam logic [31:0] SPLIT_WIN_SIZE     = 32'h0001_0000;
	localparam logic [31:0] LOCK_WIN_SIZE      = 32'h0002_0000;
	localparam logic [31:0] GLB_C0_FIRST       = 32'hFFE0_0000;
	localparam logic [31:0] GLB_C0_SECOND      = 32'hFFE2_0000;
	localparam logic [31:0] GLB_C0_ICACHE      = 32'hFFE4_0000;
	localparam logic [31:0] GLB_C1_FIRST       = 32'hFFE9_0000;
	localparam logic [31:0] GLB_C1_SECOND      = 32'hFFEB_0000;
	localparam logic [31:0] GLB_C1_ICACHE      = 32'hFFEC_0000;
	localparam logic [31:0] CACHE_WIN_SIZE     = 32'h0001_0000;
	localparam logic [13:0] SPLIT_WORD_MASK    = 14'h3FFF;
	localparam logic [14:0] LOCK_WORD_MASK     = 15'h7FFF;
	localparam logic [14:0] BANK_ONE_OFFSET    = 15'h4000;
	typedef enum logic [1:0] {
		HIT_NONE,
		HIT_MEM,
		HIT_CACHE
	} hit_kind_t;
	typedef enum logic {
		MODE_SPLIT,
		MODE_LOCK
	} group_mode_t;
	// Hamming(38,32) check bits, with the overall parity in the top bit.
	function automatic logic [CHECK_W-1:0] ecc_gen(input logic [DATA_W-1:0] d);
		logic [CHECK_W-2:0] c;
		int unsigned        pos;
		int unsigned        k;
		c   = '0;
		pos = 1;
		for (k = 0; k < DATA_W; k++)
		begin
			pos++;
			while ((pos & (pos - 1)) == 0)
				pos++;
			for (int b = 0; b < CHECK_W - 1; b++)
				if (pos[b])
					c[b] = c[b] ^ d[k];
		end
		ecc_gen = {^{d, c}, c};
	endfunction : ecc_gen
	// Returns {double error, single error, corrected data}; the stored word is not repaired.
	function automatic logic [DATA_W+1:0] ecc_fix(input logic [DATA_W+CHECK_W-1:0] w);
		logic [DATA_W-1:0]  d;
		logic [CHECK_W-1:0] c;
		logic [CHECK_W-2:0] syn;
		logic               par;
		int unsigned        pos;
		d   = w[DATA_W+CHECK_W-1:CHECK_W];
		c   = ecc_gen(d);
		syn = c[CHECK_W-2:0] ^ w[CHECK_W-2:0];
		par = ^w;
		pos = 1;
		for (int k = 0; k < DATA_W; k++)
		begin
			pos++;
			while ((pos & (pos - 1)) == 0)
				pos++;
			if (par && (syn == pos[CHECK_W-2:0]))
				d[k] = ~d[k];
		end
		ecc_fix = {(syn != '0) & ~par, par, d};
	endfunction : ecc_fix
endpackage : rpu_cfg_pkg

// [mem_port_if.sv]
`timescale 1ns/1ps
`default_nettype none
// Write and read port of one memory bank, carrying data and check bits together.
interface mem_port_if;
	logic                                     req;
	logic                                     we;
	logic [rpu_cfg_pkg::MEM_IDX_W-1:0]        idx;
	logic [rpu_cfg_pkg::DATA_W+rpu_cfg_pkg::CHECK_W-1:0] wdata;
	logic [rpu_cfg_pkg::DATA_W+rpu_cfg_pkg::CHECK_W-1:0] rdata;
	modport ctrl (output req, output we, output idx, output wdata, input rdata);
	modport mem  (input req, input we, input idx, input wdata, output rdata);
endinterface : mem_port_if
`default_nettype wire

// [tcm_bank.sv]
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// Protected word memory with registered read data.
// ****************************************************************
module tcm_bank
	import rpu_cfg_pkg::*;
(
	input  wire logic core_clk, // System clock.
	input  wire logic clk_en,   // Freezes the memory while low.
	mem_port_if.mem   port      // Access port.
);
	logic [DATA_W+CHECK_W-1:0] store [MEM_DEPTH];
	logic [DATA_W+CHECK_W-1:0] rdata_q;

	// No reset on the array so it maps onto plain RAM.
	always_ff @(posedge core_clk)
	begin
		if (clk_en && port.req)
		begin
			if (port.we)
				store[port.idx] <= port.wdata;
			rdata_q <= store[port.idx];
		end
	end

	assign port.rdata = rdata_q;
endmodule : tcm_bank
`default_nettype wire

// [rpu_lockstep_tcm_map.sv]
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// Mode select, reset fan-out, memory map, SEC-DED and lock compare.
// ****************************************************************
module rpu_lockstep_tcm_map
	import rpu_cfg_pkg::*;
(
	input  wire logic                     core_clk,         // 200 MHz system clock.
	input  wire logic                     resetn,           // Async active-low group power-on reset.
	input  wire logic                     clk_en,           // Freezes all state while low.
	input  wire logic                     lock_clamp_select, // Clamp select strap.
	input  wire logic                     split_mode_select, // Split select strap.
	input  wire logic                     core_zero_rst_req, // Reset request for core zero.
	input  wire logic                     core_one_rst_req,  // Reset request for core one.
	input  wire logic                     c0_req,           // Core zero local access.
	input  wire logic                     c0_we,            // Core zero write.
	input  wire logic [rpu_cfg_pkg::ADDR_W-1:0] c0_addr,    // Core zero local address.
	input  wire logic [rpu_cfg_pkg::DATA_W-1:0] c0_wdata,   // Core zero write data.
	input  wire logic                     c1_req,           // Core one local access.
	input  wire logic                     c1_we,            // Core one write.
	input  wire logic [rpu_cfg_pkg::ADDR_W-1:0] c1_addr,    // Core one local address.
	input  wire logic [rpu_cfg_pkg::DATA_W-1:0] c1_wdata,   // Core one write data.
	input  wire logic                     g_req,            // Global master access.
	input  wire logic                     g_we,             // Global write.
	input  wire logic [rpu_cfg_pkg::ADDR_W-1:0] g_addr,     // Global address.
	input  wire logic [rpu_cfg_pkg::DATA_W-1:0] g_wdata,    // Global write data.
	input  wire logic                     g_permit,         // Protection unit grant.
	output logic                          lockstep_q,       // Latched mode, high in lock-step.
	output logic                          core_zero_rst_q,  // Reset to core zero.
	output logic                          core_one_rst_q,   // Reset to core one.
	output logic                          core_one_visible_q, // Second interface exposed.
	output logic                          c0_ack_q,         // Core zero answer strobe.
	output logic [rpu_cfg_pkg::DATA_W-1:0] c0_rdata_q,      // Core zero read data.
	output logic                          c1_ack_q,         // Core one answer strobe.
	output logic [rpu_cfg_pkg::DATA_W-1:0] c1_rdata_q,      // Core one read data.
	output logic                          g_ack_q,          // Global answer strobe.
	output logic                          g_err_q,          // Global refused or unmapped.
	output logic [rpu_cfg_pkg::DATA_W-1:0] g_rdata_q,       // Global read data.
	output logic                          g_icache_hit_q,   // Global hit on a cache window.
	output logic                          ecc_corr_q,       // Single error corrected, pulse.
	output logic                          ecc_uncorr_q,     // Double error detected, pulse.
	output logic                          lock_mismatch_q   // Redundant core mismatch, pulse.
);
	// ****************************************************************
	// Strap sampling and mode latch.
	// ****************************************************************
	logic [2:0]  clamp_s_q, split_s_q;
	logic        in_reset_q, run_q;
	group_mode_t mode;

	// Three-stage synchronisers; a change is trusted once stages two and three agree.
	// They keep sampling under reset, so the straps are settled when the mode is latched.
	always_ff @(posedge core_clk)
	begin
		if (clk_en)
		begin
			clamp_s_q <= {clamp_s_q[1:0], lock_clamp_select};
			split_s_q <= {split_s_q[1:0], split_mode_select};
		end
	end

	// The mode is only captured on the first enabled edge after reset release, never while running.
	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			lockstep_q <= 1'b0;
			in_reset_q <= 1'b1;
			run_q      <= 1'b0;
		end
		else if (clk_en)
		begin
			in_reset_q <= 1'b0;
			run_q      <= ~in_reset_q;
			if (in_reset_q && (clamp_s_q[1] == clamp_s_q[2]) && (split_s_q[1] == split_s_q[2]))
				lockstep_q <= clamp_s_q[2] & ~split_s_q[2];
		end
	end

	assign mode = lockstep_q ? MODE_LOCK : MODE_SPLIT;

	// ****************************************************************
	// Core reset fan-out and interface exposure.
	// ****************************************************************
	// Lock-step ties core one's reset to core zero so the pair never diverges.
	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			core_zero_rst_q    <= 1'b1;
			core_one_rst_q     <= 1'b1;
			core_one_visible_q <= 1'b0;
		end
		else if (clk_en)
		begin
			core_zero_rst_q    <= core_zero_rst_req | ~run_q;
			core_one_rst_q     <= (mode == MODE_LOCK) ? (core_zero_rst_req | ~run_q)
				: (core_one_rst_req | ~run_q);
			core_one_visible_q <= run_q & (mode == MODE_SPLIT);
		end
	end

	// ****************************************************************
	// Address decode for local and global views.
	// ****************************************************************
	logic        c0_hit, c0_bank, c1_hit, c1_bank, g_core, g_bank;
	logic [14:0] c0_idx, c1_idx, g_idx;
	hit_kind_t   g_kind;
	logic [31:0] win;

	// Local view is the same for both cores in split mode; lock-step doubles core zero's window and hides core one's.
	always_comb
	begin
		win     = lockstep_q ? LOCK_WIN_SIZE : SPLIT_WIN_SIZE;
		c0_bank = (c0_addr >= LOCAL_SECOND_BASE);
		c0_hit  = c0_addr < (LOCAL_SECOND_BASE + win);
		if (!c0_bank)
			c0_hit = c0_hit & (c0_addr < LOCAL_FIRST_BASE + win);
		c0_idx  = 15'(c0_addr[ADDR_W-1:2]) & (lockstep_q ? LOCK_WORD_MASK : {1'b0, SPLIT_WORD_MASK});
		c1_bank = (c1_addr >= LOCAL_SECOND_BASE);
		c1_hit  = ~lockstep_q & (c1_addr < (c1_bank ? LOCAL_SECOND_BASE : LOCAL_FIRST_BASE) + win);
		c1_idx  = {1'b0, 14'(c1_addr[ADDR_W-1:2]) & SPLIT_WORD_MASK};
	end

	// Global decode; core one windows exist only in split mode.
	always_comb
	begin
		g_kind = HIT_NONE;
		g_core = 1'b0;
		g_bank = 1'b0;
		g_idx  = 15'(g_addr[ADDR_W-1:2]) & LOCK_WORD_MASK;
		if (g_addr >= GLB_C0_FIRST && g_addr < GLB_C0_FIRST + win)
			g_kind = HIT_MEM;
		else if (g_addr >= GLB_C0_SECOND && g_addr < GLB_C0_SECOND + win)
		begin
			g_kind = HIT_MEM;
			g_bank = 1'b1;
		end
		else if (g_addr >= GLB_C0_ICACHE && g_addr < GLB_C0_ICACHE + CACHE_WIN_SIZE)
			g_kind = HIT_CACHE;
		else if (!lockstep_q && g_addr >= GLB_C1_FIRST && g_addr < GLB_C1_FIRST + SPLIT_WIN_SIZE)
		begin
			g_kind = HIT_MEM;
			g_core = 1'b1;
		end
		else if (!lockstep_q && g_addr >= GLB_C1_SECOND && g_addr < GLB_C1_SECOND + SPLIT_WIN_SIZE)
		begin
			g_kind = HIT_MEM;
			g_core = 1'b1;
			g_bank = 1'b1;
		end
		else if (!lockstep_q && g_addr >= GLB_C1_ICACHE && g_addr < GLB_C1_ICACHE + CACHE_WIN_SIZE)
		begin
			g_kind = HIT_CACHE;
			g_core = 1'b1;
		end
		if (!lockstep_q)
			g_idx = {1'b0, g_idx[13:0]};
	end

	// ****************************************************************
	// Memory banks: bank 0 is core zero, bank 1 core one; lock-step joins them.
	// ****************************************************************
	mem_port_if bank_if[2] ();
	logic       g_go, g_blk, g_on_b0, g_on_b1, c0_loc, c1_loc, b1_loc;

	assign c0_loc  = c0_req & c0_hit & run_q;
	assign c1_loc  = c1_req & c1_hit & run_q;
	assign b1_loc  = lockstep_q ? c0_loc : c1_loc;
	assign g_blk   = g_core ? (c1_req & c1_hit & ~lockstep_q) : (c0_req & c0_hit);
	assign g_go    = g_req & run_q & (g_kind == HIT_MEM) & g_permit;
	assign g_on_b0 = g_go & ~g_blk & ~g_core & ~(lockstep_q & g_idx[14]);
	assign g_on_b1 = g_go & ~g_blk & (g_core | (lockstep_q & g_idx[14]));

	// Lock-step puts the upper half of each doubled window on core one's bank.
	// A blocked global access never reaches a bank, so it cannot borrow the local address.
	assign bank_if[0].req   = (c0_loc & ~c0_idx[14]) | g_on_b0;
	assign bank_if[0].we    = c0_loc ? c0_we : g_we;
	assign bank_if[0].idx   = c0_loc ? {c0_bank, c0_idx[13:0]} : {g_bank, g_idx[13:0]};
	assign bank_if[0].wdata = c0_loc ? {c0_wdata, ecc_gen(c0_wdata)}
		: {g_wdata, ecc_gen(g_wdata)};
	assign bank_if[1].req   = (lockstep_q ? (c0_loc & c0_idx[14]) : c1_loc) | g_on_b1;
	assign bank_if[1].we    = b1_loc ? (lockstep_q ? c0_we : c1_we) : g_we;
	assign bank_if[1].idx   = !b1_loc ? {g_bank, g_idx[13:0]}
		: lockstep_q ? {c0_bank, c0_idx[13:0]} : {c1_bank, c1_idx[13:0]};
	assign bank_if[1].wdata = !b1_loc ? {g_wdata, ecc_gen(g_wdata)}
		: lockstep_q ? {c0_wdata, ecc_gen(c0_wdata)} : {c1_wdata, ecc_gen(c1_wdata)};

	generate
		for (genvar b = 0; b < 2; b++)
		begin : g_bank_inst
			tcm_bank u_bank (
				.core_clk (core_clk),
				.clk_en   (clk_en),
				.port     (bank_if[b])
			);
		end
	endgenerate

	// ****************************************************************
	// Answer side.
	// ****************************************************************
	logic              c0_pend_q, c0_src_q, c1_pend_q, g_pend_q, g_src_q, b0_rd_q, b1_rd_q;
	logic [DATA_W+1:0] fix0, fix1;

	assign fix0  = ecc_fix(bank_if[0].rdata);
	assign fix1  = ecc_fix(bank_if[1].rdata);

	// Read data appear two edges after the request, after the registered RAM.
	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			c0_pend_q <= 1'b0;
			c0_src_q  <= 1'b0;
			c1_pend_q <= 1'b0;
			g_pend_q  <= 1'b0;
			g_src_q   <= 1'b0;
			c0_ack_q  <= 1'b0;
			c1_ack_q  <= 1'b0;
			g_ack_q   <= 1'b0;
			g_err_q   <= 1'b0;
			g_icache_hit_q <= 1'b0;
			c0_rdata_q <= '0;
			c1_rdata_q <= '0;
			g_rdata_q  <= '0;
			ecc_corr_q <= 1'b0;
			ecc_uncorr_q <= 1'b0;
			b0_rd_q    <= 1'b0;
			b1_rd_q    <= 1'b0;
		end
		else if (clk_en)
		begin
			c0_pend_q <= c0_req & c0_hit & run_q;
			c0_src_q  <= lockstep_q & c0_idx[14];
			c1_pend_q <= c1_req & c1_hit & run_q;
			g_pend_q  <= g_go & ~g_blk;
			g_src_q   <= g_on_b1;
			c0_ack_q  <= c0_pend_q;
			c1_ack_q  <= c1_pend_q;
			g_ack_q   <= g_pend_q;
			g_err_q   <= g_req & run_q & (~g_permit | (g_kind != HIT_MEM) | g_blk);
			g_icache_hit_q <= g_req & run_q & g_permit & (g_kind == HIT_CACHE);
			c0_rdata_q <= c0_src_q ? fix1[DATA_W-1:0] : fix0[DATA_W-1:0];
			c1_rdata_q <= fix1[DATA_W-1:0];
			g_rdata_q  <= g_src_q ? fix1[DATA_W-1:0] : fix0[DATA_W-1:0];
			// Only a bank that was really read may flag, so stale read data stay silent.
			b0_rd_q    <= bank_if[0].req & ~bank_if[0].we;
			b1_rd_q    <= bank_if[1].req & ~bank_if[1].we;
			ecc_corr_q <= (b0_rd_q & fix0[DATA_W]) | (b1_rd_q & fix1[DATA_W]);
			ecc_uncorr_q <= (b0_rd_q & fix0[DATA_W+1]) | (b1_rd_q & fix1[DATA_W+1]);
		end
	end

	// ****************************************************************
	// Lock-step comparator.
	// ****************************************************************
	// The redundant core must issue the same request as the primary every cycle.
	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
			lock_mismatch_q <= 1'b0;
		else if (clk_en)
			lock_mismatch_q <= lockstep_q & run_q & ~core_zero_rst_q &
				({c1_req, c1_we, c1_addr, c1_wdata} != {c0_req, c0_we, c0_addr, c0_wdata});
	end

	// ****************************************************************
	// Checks.
	// ****************************************************************
	a_mode_stable: assert property (@(posedge core_clk) disable iff (!resetn)
		run_q |=> $stable(lockstep_q)) else $error("Mode changed while running.");
	a_mode_decode: assert property (@(posedge core_clk) disable iff (!resetn)
		(clk_en && in_reset_q && clamp_s_q[1] == clamp_s_q[2] && split_s_q[1] == split_s_q[2])
		|=> lockstep_q == ($past(clamp_s_q[2]) & ~$past(split_s_q[2])))
		else $error("Mode not decoded from selects.");
	a_one_iface: assert property (@(posedge core_clk) disable iff (!resetn)
		lockstep_q |-> !core_one_visible_q) else $error("Second interface visible.");
	a_reset_follow: assert property (@(posedge core_clk) disable iff (!resetn)
		(clk_en && lockstep_q && core_zero_rst_req) |=> core_one_rst_q && core_zero_rst_q)
		else $error("Core one not reset with core zero.");
	a_split_reset: assert property (@(posedge core_clk) disable iff (!resetn)
		(clk_en && !lockstep_q && run_q && core_one_rst_req && !core_zero_rst_req)
		|=> core_one_rst_q && !core_zero_rst_q) else $error("Split reset not independent.");
	a_c1_hidden: assert property (@(posedge core_clk) disable iff (!resetn)
		(clk_en && lockstep_q && c1_req) |-> ##2 !c1_ack_q) else $error("Core one answered.");
	a_c1_global: assert property (@(posedge core_clk) disable iff (!resetn)
		(clk_en && !lockstep_q && run_q && g_req && g_permit && g_addr >= GLB_C1_FIRST
		&& g_addr < GLB_C1_FIRST + SPLIT_WIN_SIZE)
		|-> g_kind == HIT_MEM && g_core) else $error("Core one window not decoded.");
	a_c0_local: assert property (@(posedge core_clk) disable iff (!resetn)
		(clk_en && run_q && c0_req && c0_addr >= LOCAL_SECOND_BASE
		&& c0_addr < LOCAL_SECOND_BASE + SPLIT_WIN_SIZE) |-> ##2 c0_ack_q)
		else $error("Core zero local access unanswered.");
	a_permit_gate: assert property (@(posedge core_clk) disable iff (!resetn)
		(clk_en && g_req && run_q && !g_permit) |=> g_err_q ##1 !g_ack_q)
		else $error("Global access passed without grant.");
	a_ecc_clean: assert property (@(posedge core_clk) disable iff (!resetn)
		(clk_en && ecc_uncorr_q) |-> !ecc_corr_q) else $error("Double error also flagged single.");
	a_mismatch_flag: assert property (@(posedge core_clk) disable iff (!resetn)
		(clk_en && lockstep_q && run_q && !core_zero_rst_q && c1_addr != c0_addr) |=> lock_mismatch_q)
		else $error("Mismatch not flagged.");
	c_lock_run: cover property (@(posedge core_clk) disable iff (!resetn) lockstep_q && run_q);
	c_split_c1: cover property (@(posedge core_clk) disable iff (!resetn) c1_ack_q);
	c_glob_ok: cover property (@(posedge core_clk) disable iff (!resetn) g_ack_q);
	c_mismatch: cover property (@(posedge core_clk) disable iff (!resetn) lock_mismatch_q);
endmodule : rpu_lockstep_tcm_map
`default_nettype wire

// [perm_unit_model.sv]
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// Protection unit stand-in that grants global accesses to the group.
// ****************************************************************
module perm_unit_model
(
	input  wire logic        allow,   // Window opened by software.
	input  wire logic [31:0] g_addr,  // Global address under test.
	output logic             g_permit // Grant, same cycle.
);
	// Grants only inside the group range, so stray masters are refused as in silicon.
	assign g_permit = allow && (g_addr[31:20] == 12'hFFE);
endmodule : perm_unit_model
`default_nettype wire

// [testbench.sv]
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import rpu_cfg_pkg::*;
	logic        core_clk, resetn, clamp, split, c0_rq, c1_rq, perm_en;
	logic        c0_req, c0_we, c1_req, c1_we, g_req, g_we, g_permit, mirror;
	logic [31:0] c0_addr, c0_wdata, c1_addr, c1_wdata, g_addr, g_wdata;
	logic        lockstep_q, c0_rst, c1_rst, vis, c0_ack, c1_ack, g_ack, g_err, g_hit;
	logic        ecc_c, ecc_u, mism;
	logic [31:0] c0_rd, c1_rd, g_rd, rd;
	logic        ack, err, hit, ecc;
	int          failures, comparisons;
	// ****************************************************************
	// Block and far side.
	// ****************************************************************
	rpu_lockstep_tcm_map dut_u (.core_clk(core_clk), .resetn(resetn), .clk_en(1'b1),
		.lock_clamp_select(clamp), .split_mode_select(split),
		.core_zero_rst_req(c0_rq), .core_one_rst_req(c1_rq),
		.c0_req(c0_req), .c0_we(c0_we), .c0_addr(c0_addr), .c0_wdata(c0_wdata),
		.c1_req(c1_req), .c1_we(c1_we), .c1_addr(c1_addr), .c1_wdata(c1_wdata),
		.g_req(g_req), .g_we(g_we), .g_addr(g_addr), .g_wdata(g_wdata),
		.g_permit(g_permit), .lockstep_q(lockstep_q), .core_zero_rst_q(c0_rst),
		.core_one_rst_q(c1_rst), .core_one_visible_q(vis), .c0_ack_q(c0_ack),
		.c0_rdata_q(c0_rd), .c1_ack_q(c1_ack), .c1_rdata_q(c1_rd), .g_ack_q(g_ack),
		.g_err_q(g_err), .g_rdata_q(g_rd), .g_icache_hit_q(g_hit),
		.ecc_corr_q(ecc_c), .ecc_uncorr_q(ecc_u), .lock_mismatch_q(mism));
	perm_unit_model perm_u (.allow(perm_en), .g_addr(g_addr), .g_permit(g_permit));
	// The clock toggles every half period of 2.5 ns.
	always #2.5 core_clk = ~core_clk;
	task automatic complete_run();
		if (failures == 0 && comparisons > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : complete_run
	task automatic check_bit(input string what, input logic exp, input logic got);
		comparisons++;
		if (got !== exp)
		begin
			failures++;
			$display("MISMATCH %s expected %b seen %b", what, exp, got);
		end
	endtask : check_bit
	task automatic check_word(input string what, input logic [31:0] exp, input logic [31:0] got);
		comparisons++;
		if (got !== exp)
		begin
			failures++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask : check_word
	task automatic cycles(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask : cycles
	// Straps settle during the whole reset, whose three edges just match the three-edge sync depth.
	task automatic do_reset(input logic cl, input logic sp);
		@(posedge core_clk);
		#1;
		resetn = 1'b0;
		clamp = cl;
		split = sp;
		cycles(3);
		resetn = 1'b1;
		cycles(5);
	endtask : do_reset
	// One access: sel 0 core zero, 1 core one, 2 global; core one copies core zero when mirrored.
	task automatic access(input int sel, input logic we, input logic [31:0] a, input logic [31:0] d);
		c0_req = (sel == 0);
		c1_req = (sel == 1) || (mirror && sel == 0);
		g_req = (sel == 2);
		{c0_we, c1_we, g_we} = {3{we}};
		{c0_addr, c1_addr, g_addr} = {3{a}};
		{c0_wdata, c1_wdata, g_wdata} = {3{d}};
		cycles(1);
		{c0_req, c1_req, g_req} = 3'b000;
		err = g_err;
		hit = g_hit;
		cycles(1);
		ack = (sel == 0) ? c0_ack : (sel == 1) ? c1_ack : g_ack;
		rd = (sel == 0) ? c0_rd : (sel == 1) ? c1_rd : g_rd;
		ecc = ecc_c | ecc_u;
	endtask : access
	task automatic read_word(input int sel, input logic [31:0] a, input logic [31:0] exp);
		access(sel, 1'b0, a, 32'h0000_0000);
		check_bit("read ack", 1'b1, ack);
		check_word("read data", exp, rd);
		check_bit("ecc flag", 1'b0, ecc);
	endtask : read_word
	task automatic test_split();
		do_reset(1'b0, 1'b1);
		check_bit("lockstep", 1'b0, lockstep_q);
		check_bit("core one visible", 1'b1, vis);
		access(0, 1'b1, 32'h0000_0010, 32'hA5A5_0001);
		check_bit("write ack", 1'b1, ack);
		access(0, 1'b1, 32'h0002_0020, 32'h5A5A_0002);
		access(1, 1'b1, 32'h0000_0010, 32'h1234_5678);
		read_word(0, 32'h0000_0010, 32'hA5A5_0001);
		read_word(2, 32'hFFE0_0010, 32'hA5A5_0001);
		read_word(2, 32'hFFE2_0020, 32'h5A5A_0002);
		read_word(2, 32'hFFE9_0010, 32'h1234_5678);
		read_word(1, 32'h0000_0010, 32'h1234_5678);
		access(2, 1'b0, 32'hFFE4_0000, 32'h0000_0000);
		check_bit("cache hit", 1'b1, hit);
		check_bit("cache err", 1'b1, err);
		perm_en = 1'b0;
		access(2, 1'b0, 32'hFFE0_0010, 32'h0000_0000);
		check_bit("denied err", 1'b1, err);
		check_bit("denied ack", 1'b0, ack);
		perm_en = 1'b1;
		c1_rq = 1'b1;
		cycles(4);
		check_bit("c1 reset", 1'b1, c1_rst);
		check_bit("c0 reset", 1'b0, c0_rst);
		c1_rq = 1'b0;
		clamp = 1'b1;
		split = 1'b0;
		cycles(6);
		check_bit("mode held", 1'b0, lockstep_q);
	endtask : test_split
	task automatic test_lock();
		do_reset(1'b1, 1'b0);
		// Work is dispatched to core zero only; core one merely shadows it.
		mirror = 1'b1;
		check_bit("lockstep", 1'b1, lockstep_q);
		check_bit("core one visible", 1'b0, vis);
		access(0, 1'b1, 32'h0001_0040, 32'hCAFE_0003);
		check_bit("upper write ack", 1'b1, ack);
		read_word(0, 32'h0001_0040, 32'hCAFE_0003);
		read_word(2, 32'hFFE1_0040, 32'hCAFE_0003);
		access(2, 1'b0, 32'hFFE9_0010, 32'h0000_0000);
		check_bit("split window gone", 1'b1, err);
		mirror = 1'b0;
		c1_req = 1'b1;
		c1_addr = 32'h0000_0040;
		cycles(1);
		c1_req = 1'b0;
		check_bit("mismatch", 1'b1, mism);
		cycles(2);
		check_bit("core one ack", 1'b0, c1_ack);
		c0_rq = 1'b1;
		cycles(4);
		check_bit("c1 reset", 1'b1, c1_rst);
		check_bit("c0 reset", 1'b1, c0_rst);
		c0_rq = 1'b0;
		split = 1'b1;
		cycles(6);
		check_bit("mode held", 1'b1, lockstep_q);
	endtask : test_lock
	// Every input gets a value at time zero, then the scenarios run in turn.
	initial
	begin
		{core_clk, resetn, clamp, split, c0_rq, c1_rq, mirror} = 7'h00;
		{c0_req, c0_we, c1_req, c1_we, g_req, g_we} = 6'h00;
		{c0_addr, c0_wdata, c1_addr, c1_wdata, g_addr, g_wdata} = '0;
		perm_en = 1'b1;
		failures = 0;
		comparisons = 0;
		test_split();
		test_lock();
		complete_run();
	end
	// Both scenarios need about 70 cycles; the limit leaves wide margin for a hang.
	initial
	begin
		#20000;
		failures++;
		complete_run();
	end
endmodule : testbench
`default_nettype wire
